// file: hw/flr_top.sv
// Fault log recorder: RAM ring, nonvolatile copy, status flags, block read
// Notes on behaviour
// - Erase command wipes the whole nonvolatile log.
// - Copy-held flag set on transfer, cleared by erase unless a fault fires that cycle.
// - Frozen flag set on recall, cleared by read.
// - Buffer refreshes per conversion unless frozen.
// - Copy-held one blocks further nonvolatile transfers.
// - Enabled, unblocked fault or save triggers transfer.
// - Copy-held flag survives resets via nonvolatile cell.
// - Discharge and fault-pin events never trigger transfer.
// - Read-only block read returns 255-byte RAM copy.
// - Byte 0 pointer snapshot, bytes 1-6 timestamp.
// - 41-bit tick count, 200us steps, cleared at reset.
// - Bytes 7-46 hold peak/min pairs, low first.
// - Bytes 47-237 record; 238-254 read as zero.
// - Byte 47 is snapshot position, then descending.
// - Loop of 40 positions, reserved at 11, 23.
// - Block read sends count 0xFF, then pointer.
// - Save copies RAM out; recall copies log back.
`timescale 1ns/10ps
`default_nettype none

module flr_top #(
  parameter int TICK_CYCLES = flr_pkg::TICK_CYCLES
) (
  input  wire logic                     clk_sys,
  input  wire logic                     rstn,
  input  wire logic                     clk_link,
  input  wire flr_pkg::flr_cmd_t        cmd,
  input  wire flr_pkg::flr_tel_t        tel,
  input  wire flr_pkg::flr_pm_t [9:0]   pm_live,
  input  wire logic                     fault_latchoff,
  input  wire logic                     log_capture_en,
  input  wire logic                     nv_held_strap,
  input  wire logic                     lk_req,
  input  wire logic                     lk_kind,
  output logic                          lk_ready,
  output logic                    [7:0] lk_data,
  output logic                          lk_valid,
  output logic                    [7:0] status_flags
);

  localparam int PW = $clog2(TICK_CYCLES + 1);

  // ==========================================
  // Declarations
  logic                            strap_s;
  logic                      [1:0] load_cnt_r;
  logic                            loaded_r;
  logic                            nv_held_r;
  logic                            frozen_r;
  logic                   [PW-1:0] pre_cnt_r;
  logic         [flr_pkg::TS_W-1:0] tick_r;
  logic                      [7:0] waddr_r;
  logic                      [5:0] wpos_r;
  logic                      [7:0] addr_last;
  logic                      [5:0] pos_last;
  logic                      [7:0] ring_mem [0:flr_pkg::RING_DEPTH-1];
  flr_pkg::flr_pm_t          [9:0] pm_ram_r;
  logic                      [5:0] snap_pos_r;
  logic                      [7:0] snap_addr_r;
  logic         [flr_pkg::TS_W-1:0] snap_ts_r;
  logic                      [7:0] nv_ring [0:flr_pkg::RING_DEPTH-1];
  flr_pkg::flr_pm_t          [9:0] nv_pm;
  logic                      [5:0] nv_pos;
  logic                      [7:0] nv_addr;
  logic         [flr_pkg::TS_W-1:0] nv_ts;
  logic                            do_clear;
  logic                            do_store;
  logic                            do_restore;
  logic                            fire;
  logic                            ram_upd;
  logic                      [5:0] snap_pos_nxt;
  logic                      [7:0] snap_addr_nxt;
  logic         [flr_pkg::TS_W-1:0] snap_ts_nxt;
  logic                            sy_req;
  logic                            sy_kind;
  logic                      [7:0] reply_r;
  logic                            ack_r;
  logic                      [7:0] rd_idx_r;
  logic                            rd_act_r;
  logic                            rd_done;
  logic                      [7:0] blk_byte;

  // ==========================================
  // Command decode
  assign do_clear   = cmd.valid && (cmd.code == flr_pkg::FLR_CMD_CLEAR);
  assign do_store   = cmd.valid && (cmd.code == flr_pkg::FLR_CMD_STORE);
  assign do_restore = cmd.valid && (cmd.code == flr_pkg::FLR_CMD_RESTORE);

  // Only latch-off faults and save; no discharge or fault-pin input
  assign fire = loaded_r && log_capture_en && !nv_held_r
                && (fault_latchoff || do_store);

  // ==========================================
  // Nonvolatile flag reload after reset
  flr_sync #(.W(1)) u_strap_sync (
    .clk  (clk_sys),
    .rstn (rstn),
    .d    (nv_held_strap),
    .q    (strap_s)
  );

  // Wait for the synchroniser to settle before trusting the cell level
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      load_cnt_r <= 2'h0;
      loaded_r   <= 1'b0;
    end
    else if (!loaded_r)
    begin
      load_cnt_r <= load_cnt_r + 2'h1;
      loaded_r   <= (load_cnt_r == flr_pkg::NV_LOAD_WAIT);
    end
  end

  // Copy-held flag; the outside cell keeps its value over power loss
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      nv_held_r <= flr_pkg::NV_HELD_RST;
    else if (!loaded_r)
      nv_held_r <= (load_cnt_r == flr_pkg::NV_LOAD_WAIT) ? strap_s : nv_held_r;
    else if (fire)
      nv_held_r <= 1'b1;
    else if (do_clear)
      nv_held_r <= 1'b0;
  end

  // Frozen flag; a recall in the cycle a read finishes wins
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      frozen_r <= flr_pkg::FROZEN_RST;
    else if (do_restore)
      frozen_r <= 1'b1;
    else if (rd_done)
      frozen_r <= 1'b0;
  end

  always_comb
  begin
    status_flags                        = 8'h00;
    status_flags[flr_pkg::STAT_NV_BIT]  = nv_held_r;
    status_flags[flr_pkg::STAT_RAM_BIT] = frozen_r;
  end

  // ==========================================
  // Shared tick counter
  // Free-running from reset; wide enough never to wrap in service
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      pre_cnt_r <= '0;
      tick_r    <= '0;
    end
    else if (pre_cnt_r == PW'(TICK_CYCLES - 1))
    begin
      pre_cnt_r <= '0;
      tick_r    <= tick_r + 41'h1;
    end
    else
      pre_cnt_r <= pre_cnt_r + PW'(1);
  end

  // ==========================================
  // Ring write pointer
  assign ram_upd = tel.valid && !frozen_r && !do_restore;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      waddr_r <= 8'h00;
      wpos_r  <= 6'h00;
    end
    else if (ram_upd)
    begin
      waddr_r <= (waddr_r == 8'(flr_pkg::RING_DEPTH - 1)) ? 8'h00 : waddr_r + 8'h01;
      wpos_r  <= (wpos_r == 6'(flr_pkg::LOOP_LEN - 1)) ? 6'h00 : wpos_r + 6'h01;
    end
  end

  // Entry most recently written
  assign addr_last = (waddr_r == 8'h00) ? 8'(flr_pkg::RING_DEPTH - 1) : waddr_r - 8'h01;
  assign pos_last  = (wpos_r == 6'h00) ? 6'(flr_pkg::LOOP_LEN - 1) : wpos_r - 6'h01;

  // Snapshot is only retaken while the RAM is live
  always_comb
  begin
    snap_pos_nxt  = snap_pos_r;
    snap_addr_nxt = snap_addr_r;
    snap_ts_nxt   = snap_ts_r;
    if (fire && !frozen_r)
    begin
      snap_pos_nxt  = pos_last;
      snap_addr_nxt = addr_last;
      snap_ts_nxt   = tick_r;
    end
  end

  // ==========================================
  // RAM log: ring, peak/min copy and snapshot
  // Ring has no reset; it is storage, and reads before a fault are don't-care
  always_ff @(posedge clk_sys)
  begin
    if (do_restore)
      ring_mem <= nv_ring;
    else if (ram_upd)
    begin
      if (wpos_r == flr_pkg::RSV_POS_VIN || wpos_r == flr_pkg::RSV_POS_TEMP)
        ring_mem[waddr_r] <= 8'h00;
      else
        ring_mem[waddr_r] <= tel.data;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      pm_ram_r    <= '0;
      snap_pos_r  <= 6'h00;
      snap_addr_r <= 8'h00;
      snap_ts_r   <= '0;
    end
    else if (do_restore)
    begin
      pm_ram_r    <= nv_pm;
      snap_pos_r  <= nv_pos;
      snap_addr_r <= nv_addr;
      snap_ts_r   <= nv_ts;
    end
    else
    begin
      if (ram_upd)
        pm_ram_r <= pm_live;
      snap_pos_r  <= snap_pos_nxt;
      snap_addr_r <= snap_addr_nxt;
      snap_ts_r   <= snap_ts_nxt;
    end
  end

  // ==========================================
  // Nonvolatile copy
  // Whole image moves in one cycle; cell programming lies outside
  always_ff @(posedge clk_sys)
  begin
    if (do_clear)
    begin
      for (int i = 0; i < flr_pkg::RING_DEPTH; i++)
        nv_ring[i] <= 8'h00;
      nv_pm   <= '0;
      nv_pos  <= 6'h00;
      nv_addr <= 8'h00;
      nv_ts   <= '0;
    end
    else if (fire)
    begin
      nv_ring <= ring_mem;
      nv_pm   <= pm_ram_r;
      nv_pos  <= snap_pos_nxt;
      nv_addr <= snap_addr_nxt;
      nv_ts   <= snap_ts_nxt;
    end
  end

  // ==========================================
  // Block byte selection
  always_comb
  begin
    logic [47:0] ts_ext;
    logic  [7:0] pi;
    logic  [7:0] off;
    logic  [8:0] ra;
    logic [15:0] word;
    ts_ext   = {7'h00, snap_ts_r};
    pi       = rd_idx_r - 8'(flr_pkg::PM_FIRST);
    off      = rd_idx_r - 8'(flr_pkg::LOOP_FIRST);
    ra       = 9'h000;
    word     = 16'h0000;
    blk_byte = 8'h00;
    if (rd_idx_r == 8'h00)
      blk_byte = {2'h0, snap_pos_r};
    else if (rd_idx_r <= 8'(flr_pkg::TS_LAST))
      blk_byte = ts_ext[(rd_idx_r - 8'h01) * 8 +: 8];
    else if (rd_idx_r < 8'(flr_pkg::LOOP_FIRST))
    begin
      word     = pi[1] ? pm_ram_r[pi[5:2]].min : pm_ram_r[pi[5:2]].peak;
      blk_byte = pi[0] ? word[15:8] : word[7:0];
    end
    else if (rd_idx_r <= 8'(flr_pkg::LOOP_LAST))
    begin
      // Walk backwards from the snapshot entry, wrapping
      if (snap_addr_r >= off)
        ra = {1'b0, snap_addr_r - off};
      else
        ra = {1'b0, snap_addr_r} + 9'(flr_pkg::RING_DEPTH) - {1'b0, off};
      blk_byte = ring_mem[ra[7:0]];
    end
  end

  // ==========================================
  // Block read
  flr_hs u_hs (
    .clk_link (clk_link),
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .lk_req   (lk_req),
    .lk_kind  (lk_kind),
    .lk_ready (lk_ready),
    .lk_data  (lk_data),
    .lk_valid (lk_valid),
    .sy_req   (sy_req),
    .sy_kind  (sy_kind),
    .sy_data  (reply_r),
    .sy_ack   (ack_r)
  );

  // Completion only counts when all 255 data bytes were fetched
  assign rd_done = sy_req && !sy_kind && rd_act_r
                   && (rd_idx_r == 8'(flr_pkg::BLOCK_LEN - 1));

  // Reply and acknowledge are registered on the same edge; reads change no log state
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      reply_r  <= 8'h00;
      ack_r    <= 1'b0;
      rd_idx_r <= 8'h00;
      rd_act_r <= 1'b0;
    end
    else
    begin
      ack_r <= sy_req;
      if (sy_req && sy_kind)
      begin
        reply_r  <= flr_pkg::BYTE_COUNT;
        rd_idx_r <= 8'h00;
        rd_act_r <= 1'b1;
      end
      else if (sy_req && rd_act_r)
      begin
        reply_r  <= blk_byte;
        rd_idx_r <= rd_idx_r + 8'h01;
        rd_act_r <= !rd_done;
      end
      else if (sy_req)
        reply_r <= 8'h00;
    end
  end

endmodule

`default_nettype wire

// file: hw/flr_pkg.sv
// Shared constants and types for the fault log recorder
package flr_pkg;

  // ==========================================
  // Block layout
  localparam int BLOCK_LEN  = 255;  // Data bytes after the count
  localparam int TS_LAST    = 6;    // Timestamp bytes 1..6
  localparam int PM_FIRST   = 7;    // Peak/min pairs 7..46
  localparam int LOOP_FIRST = 47;   // Chronological record start
  localparam int LOOP_LAST  = 237;  // Last valid byte
  localparam int LOOP_LEN   = 40;   // Positions per loop
  localparam int RING_DEPTH = 200;  // Five loops of storage
  localparam int PM_QTY     = 10;   // Eight outputs, input, temp
  localparam int TS_W       = 41;

  localparam logic [5:0] RSV_POS_VIN  = 6'h0B;
  localparam logic [5:0] RSV_POS_TEMP = 6'h17;
  localparam logic [7:0] BYTE_COUNT   = 8'hFF;

  // ==========================================
  // Status register fields and reset values
  localparam int         STAT_NV_BIT  = 0;
  localparam int         STAT_RAM_BIT = 1;
  localparam logic       NV_HELD_RST  = 1'b0;
  localparam logic       FROZEN_RST   = 1'b0;
  localparam logic [1:0] NV_LOAD_WAIT = 2'h2;  // Synchroniser depth

  // ==========================================
  // Timing
  localparam int TICK_NS     = 200000;  // Shared tick step
  localparam int CLK_NS      = 10;
  localparam int TICK_CYCLES = (TICK_NS + CLK_NS - 1) / CLK_NS;

  // ==========================================
  // Types
  typedef enum logic [2:0] {
    FLR_CMD_CLEAR   = 3'h1,
    FLR_CMD_STORE   = 3'h2,
    FLR_CMD_RESTORE = 3'h4
  } flr_cmd_code_t;

  typedef struct packed {
    logic          valid;
    flr_cmd_code_t code;
  } flr_cmd_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } flr_tel_t;

  typedef struct packed {
    logic [15:0] peak;
    logic [15:0] min;
  } flr_pm_t;

endpackage

// file: hw/flr_sync.sv
// Two-stage level synchroniser
`timescale 1ns/10ps
`default_nettype none

module flr_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_r <= '0;
      q      <= '0;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

`default_nettype wire

// file: hw/flr_hs.sv
// Toggle handshake carrying byte requests and replies across clocks
`timescale 1ns/10ps
`default_nettype none

module flr_hs (
  input  wire logic       clk_link,
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       lk_req,
  input  wire logic       lk_kind,
  output logic            lk_ready,
  output logic      [7:0] lk_data,
  output logic            lk_valid,
  output logic            sy_req,
  output logic            sy_kind,
  input  wire logic [7:0] sy_data,
  input  wire logic       sy_ack
);

  logic req_tgl_r;
  logic kind_r;
  logic ack_tgl_r;
  logic req_s;
  logic req_seen_r;
  logic ack_s;
  logic ack_seen_r;

  // ==========================================
  // Link side
  // Kind is held until the reply returns, so it is stable when sampled
  always_ff @(posedge clk_link or negedge rstn)
  begin
    if (!rstn)
    begin
      req_tgl_r <= 1'b0;
      kind_r    <= 1'b0;
    end
    else if (lk_req && lk_ready)
    begin
      req_tgl_r <= ~req_tgl_r;
      kind_r    <= lk_kind;
    end
  end

  flr_sync #(.W(1)) u_ack_sync (
    .clk  (clk_link),
    .rstn (rstn),
    .d    (ack_tgl_r),
    .q    (ack_s)
  );

  // Reply arrives; sys data is held stable until the next request
  always_ff @(posedge clk_link or negedge rstn)
  begin
    if (!rstn)
    begin
      ack_seen_r <= 1'b0;
      lk_valid   <= 1'b0;
      lk_data    <= 8'h00;
    end
    else
    begin
      ack_seen_r <= ack_s;
      lk_valid   <= ack_s ^ ack_seen_r;
      if (ack_s ^ ack_seen_r)
        lk_data <= sy_data;
    end
  end

  assign lk_ready = (req_tgl_r == ack_seen_r);

  // ==========================================
  // System side
  flr_sync #(.W(1)) u_req_sync (
    .clk  (clk_sys),
    .rstn (rstn),
    .d    (req_tgl_r),
    .q    (req_s)
  );

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      req_seen_r <= 1'b0;
      ack_tgl_r  <= 1'b0;
    end
    else
    begin
      req_seen_r <= req_s;
      if (sy_ack)
        ack_tgl_r <= ~ack_tgl_r;
    end
  end

  assign sy_req  = req_s ^ req_seen_r;
  assign sy_kind = kind_r;

endmodule

`default_nettype wire

// file: testbench/flr_top_sva.sv
// Port assertions for the fault log recorder
`timescale 1ns/10ps
`default_nettype none

module flr_top_sva #(
  parameter int TICK_CYCLES = flr_pkg::TICK_CYCLES
) (
  input wire logic              clk_sys,
  input wire logic              rstn,
  input wire logic              clk_link,
  input wire flr_pkg::flr_cmd_t cmd,
  input wire logic              fault_latchoff,
  input wire logic              log_capture_en,
  input wire logic              lk_req,
  input wire logic              lk_ready,
  input wire logic              lk_valid,
  input wire logic [7:0]        status_flags
);
  // ==========================================
  // Helpers
  logic [2:0] ld_r;
  wire logic  ld;
  wire logic  c_clr;
  wire logic  c_st;
  wire logic  c_rs;

  // Flag cell reload takes three edges, so wait five
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      ld_r <= 3'h0;
    else if (ld_r != 3'h5)
      ld_r <= ld_r + 3'h1;

  // Decoded commands
  assign ld    = (ld_r == 3'h5);
  assign c_clr = cmd.valid && (cmd.code == flr_pkg::FLR_CMD_CLEAR);
  assign c_st  = cmd.valid && (cmd.code == flr_pkg::FLR_CMD_STORE);
  assign c_rs  = cmd.valid && (cmd.code == flr_pkg::FLR_CMD_RESTORE);

  // ==========================================
  // Status flags
  clear_nv_a:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      ld && c_clr && !fault_latchoff |=> !status_flags[0]) else $error("Erase left copy flag set");
  store_set_a:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      ld && log_capture_en && c_st |=> status_flags[0]) else $error("Save did not set copy flag");
  fault_set_a:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      ld && log_capture_en && fault_latchoff |=> status_flags[0]) else $error("Fault did not set copy flag");
  nv_stick_a:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      ld && status_flags[0] && !c_clr |=> status_flags[0]) else $error("Copy flag dropped");
  nv_cause_a:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      ld && status_flags[0] && !$past(status_flags[0]) |->
        $past(log_capture_en) && ($past(c_st) || $past(fault_latchoff))) else $error("Copy flag rose unprompted");
  restore_set_a:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      c_rs |=> status_flags[1]) else $error("Recall did not freeze");
  frz_cause_a:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      ld && $rose(status_flags[1]) |-> $past(c_rs)) else $error("Freeze without recall");

  // ==========================================
  // Link handshake
  answer_a:
    assert property (@(posedge clk_link) disable iff (!rstn)
      lk_req && lk_ready |-> ##[1:7] lk_valid) else $error("No reply in time");
  busy_a:
    assert property (@(posedge clk_link) disable iff (!rstn)
      lk_req && lk_ready |=> !lk_ready until lk_valid) else $error("Ready during request");
  pulse_a:
    assert property (@(posedge clk_link) disable iff (!rstn)
      lk_valid |=> !lk_valid) else $error("Reply longer than a cycle");
endmodule

bind flr_top flr_top_sva #(
  .TICK_CYCLES(TICK_CYCLES)
) flr_top_sva_inst (
  .clk_sys        (clk_sys),
  .rstn           (rstn),
  .clk_link       (clk_link),
  .cmd            (cmd),
  .fault_latchoff (fault_latchoff),
  .log_capture_en (log_capture_en),
  .lk_req         (lk_req),
  .lk_ready       (lk_ready),
  .lk_valid       (lk_valid),
  .status_flags   (status_flags)
);

`default_nettype wire

// file: testbench/flr_host.sv
// Host model fetching log bytes over the link handshake
`timescale 1ns/10ps
`default_nettype none

module flr_host (
  input  wire logic       clk_link,
  input  wire logic       lk_ready,
  input  wire logic [7:0] lk_data,
  input  wire logic       lk_valid,
  output logic            lk_req,
  output logic            lk_kind
);
  // Idle request lines
  initial
  begin
    lk_req  = 1'b0;
    lk_kind = 1'b0;
  end

  // One request, held past the taking edge; the link has no bus timeout
  task automatic xfer(input logic kind, input int gap, output logic [7:0] d, output logic ok);
    int n;
    n = 0;
    d = 8'h00;
    repeat (gap + 1) @(negedge clk_link);
    while (!lk_ready && n < 30)
    begin
      @(negedge clk_link);
      n++;
    end
    lk_req  = 1'b1;
    lk_kind = kind;  // Start yields the count byte first
    @(posedge clk_link);
    @(negedge clk_link);
    lk_req  = 1'b0;
    lk_kind = ~kind;  // Released line must not keep its value
    n = 0;
    while (!lk_valid && n < 12)
    begin
      @(negedge clk_link);
      n++;
    end
    ok = lk_valid;
    d  = lk_data;
  endtask
endmodule

`default_nettype wire

// file: testbench/flr_top_tb.sv
// Self-checking bench for the fault log recorder
`timescale 1ns/10ps
`default_nettype none

module flr_top_tb;
  localparam int TC = 4;  // Short tick keeps the run brief

  logic                   clk_sys;
  logic                   clk_link;
  logic                   rstn;
  flr_pkg::flr_cmd_t      cmd;
  flr_pkg::flr_tel_t      tel;
  flr_pkg::flr_pm_t [9:0] pm_live;
  logic                   fault_latchoff;
  logic                   log_capture_en;
  logic                   nv_held_strap;
  logic                   lk_req;
  logic                   lk_kind;
  logic                   lk_ready;
  logic [7:0]             lk_data;
  logic                   lk_valid;
  logic [7:0]             status_flags;
  int                     miscompares;
  int                     cmp_count;
  int                     seed;
  int                     npos;
  int                     ring[$];
  int                     img[0:254];
  logic                   frz;
  time                    t_rel;
  time                    t_st;

  flr_top #(.TICK_CYCLES(TC)) flr_top_inst (
    .clk_sys(clk_sys), .rstn(rstn), .clk_link(clk_link), .cmd(cmd), .tel(tel), .pm_live(pm_live),
    .fault_latchoff(fault_latchoff), .log_capture_en(log_capture_en), .nv_held_strap(nv_held_strap),
    .lk_req(lk_req), .lk_kind(lk_kind), .lk_ready(lk_ready), .lk_data(lk_data), .lk_valid(lk_valid),
    .status_flags(status_flags)
  );

  flr_host flr_host_inst (
    .clk_link(clk_link), .lk_ready(lk_ready), .lk_data(lk_data), .lk_valid(lk_valid),
    .lk_req(lk_req), .lk_kind(lk_kind)
  );

  // ==========================================
  // Clocks; link offset so edges never line up
  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;
  initial clk_link = 1'b0;
  always
  begin
    #3.1;
    forever #80 clk_link = ~clk_link;
  end

  // ==========================================
  // Helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("Compares %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic do_reset();
    @(negedge clk_sys);
    rstn = 1'b0;
    repeat (20) @(negedge clk_sys);
    rstn  = 1'b1;
    t_rel = $time;
    npos  = 0;
    frz   = 1'b0;
    repeat (6) @(negedge clk_sys);
  endtask

  // One-cycle pulses; flags are read one cycle later
  task automatic send_cmd(input flr_pkg::flr_cmd_code_t c, input logic flt);
    @(negedge clk_sys);
    cmd            = '{!flt, c};
    fault_latchoff = flt;
    @(negedge clk_sys);
    cmd.valid      = 1'b0;
    fault_latchoff = 1'b0;
  endtask

  task automatic new_pm();
    for (int q = 0; q < 10; q++)
      pm_live[q] = {16'($random(seed)), 16'($random(seed))};
  endtask

  // Back-to-back bytes; model skips them while frozen
  task automatic put_tel(input int n);
    int p;
    repeat (n)
    begin
      @(negedge clk_sys);
      tel = '{1'b1, 8'($random(seed))};
      p   = npos % 40;
      if (!frz)
      begin
        ring.push_back((p == int'(flr_pkg::RSV_POS_VIN) || p == int'(flr_pkg::RSV_POS_TEMP)) ? 0 : int'(tel.data));
        npos++;
      end
    end
    @(negedge clk_sys);
    tel.valid = 1'b0;
  endtask

  // Expected block from the model at a capture
  function automatic void mk_img();
    int last;
    last   = ring.size() - 1;
    img[0] = (npos - 1) % 40;
    for (int q = 0; q < 10; q++)
    begin
      img[7+4*q]  = int'(pm_live[q].peak[7:0]);
      img[8+4*q]  = int'(pm_live[q].peak[15:8]);
      img[9+4*q]  = int'(pm_live[q].min[7:0]);
      img[10+4*q] = int'(pm_live[q].min[15:8]);
    end
    for (int j = 0; j < 208; j++)
      img[47+j] = (j < 191) ? ring[last-j] : 0;
  endfunction

  // Full block read; timestamp allowed a couple of ticks of slack
  task automatic read_chk();
    logic [7:0]  d;
    logic [47:0] ts;
    logic        ok;
    int          et;
    ts = 48'h0;
    et = int'((t_st - t_rel) / (TC * 10));
    for (int k = -1; k < 255; k++)
    begin
      flr_host_inst.xfer(k < 0, int'($random(seed)) & 3, d, ok);
      if (!ok)
      begin
        miscompares++;
        end_of_test();
      end
      if (k < 0)
        check(d, flr_pkg::BYTE_COUNT);
      else if (k >= 1 && k <= 6)
        ts[8*(k-1) +: 8] = d;
      else
        check(d, 8'(img[k]));
    end
    check(8'(ts[47:41] == 7'h00 && int'(ts) >= et - 2 && int'(ts) <= et + 2), 8'h01);
  endtask

  // ==========================================
  // Main sequence
  initial
  begin
    seed           = 32'h13B6;
    miscompares    = 0;
    cmp_count      = 0;
    rstn           = 1'b0;
    cmd            = '{1'b0, flr_pkg::FLR_CMD_CLEAR};
    tel            = '{1'b0, 8'h00};
    fault_latchoff = 1'b0;
    log_capture_en = 1'b0;
    nv_held_strap  = 1'b0;
    new_pm();
    do_reset();
    check(status_flags, 8'h00);
    send_cmd(flr_pkg::FLR_CMD_STORE, 1'b0);
    send_cmd(flr_pkg::FLR_CMD_STORE, 1'b1);
    check(status_flags, 8'h00);
    $display("Test 1 done: capture disabled");
    log_capture_en = 1'b1;
    put_tel(230);
    mk_img();
    t_st = $time;
    send_cmd(flr_pkg::FLR_CMD_STORE, 1'b1);
    check(status_flags, 8'h01);
    new_pm();
    put_tel(40);
    send_cmd(flr_pkg::FLR_CMD_STORE, 1'b0);
    send_cmd(flr_pkg::FLR_CMD_RESTORE, 1'b0);
    frz = 1'b1;
    check(status_flags, 8'h03);
    new_pm();
    put_tel(20);
    read_chk();
    repeat (10) @(negedge clk_sys);
    check(status_flags, 8'h01);
    $display("Test 2 done: capture, recall, read");
    send_cmd(flr_pkg::FLR_CMD_CLEAR, 1'b0);
    check(status_flags, 8'h00);
    send_cmd(flr_pkg::FLR_CMD_STORE, 1'b0);
    check(status_flags, 8'h01);
    $display("Test 3 done: erase and save");
    nv_held_strap = 1'b1;
    do_reset();
    check(status_flags, 8'h01);
    send_cmd(flr_pkg::FLR_CMD_CLEAR, 1'b0);
    check(status_flags, 8'h00);
    $display("Test 4 done: flag kept over reset");
    // Erased image recalled: every block byte but the timestamp must read zero
    send_cmd(flr_pkg::FLR_CMD_RESTORE, 1'b0);
    check(status_flags, 8'h02);
    img  = '{default: 0};
    t_st = t_rel;
    read_chk();
    repeat (10) @(negedge clk_sys);
    check(status_flags, 8'h00);
    $display("Test 5 done: erased log reads back as zero");
    end_of_test();
  end
endmodule

`default_nettype wire
